/* File: rtl/fdh_host.sv */
// Host-side controller driving the flash disk SRAM-like port
// Behaviour
// - Host drives 13-bit byte address
// - Select and strobes are active low
// - Write while select and write strobe low
// - Read while select and read strobe low
// - Host software corrects, using the signature
// - Code corrects two symbols, 11-bit burst
// - Code detects 31-bit bursts, 4 bits
// - Control register write sequence changes mode
module fdh_host
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Command side
   input wire logic i_cmd_valid,
   input wire fdh_pkg::cmd_t i_cmd,
   output logic o_cmd_ready,
   // Page fill and drain
   input wire logic i_pg_wvalid,
   input wire logic [7:0] i_pg_wdata,
   output logic o_pg_wready,
   output logic o_pg_rvalid,
   output logic [7:0] o_pg_rdata,
   // Results
   output logic o_done,
   output logic [7:0] o_rdata,
   output logic [47:0] o_sig,
   // Device pins
   output logic [12:0] o_addr,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output fdh_pkg::strobe_t o_strb_n
);

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_FILL = 3'h1,
      ST_SETUP = 3'h2,
      ST_STROBE = 3'h3,
      ST_HOLD = 3'h4,
      ST_NEXT = 3'h5
   } state_t;

   // ------------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------------
   // Byte address of one element inside the flash window section
   function automatic logic [12:0] flash_addr(input logic [12:0] base);
      flash_addr = {fdh_pkg::SEC_FLASH, base[10:0]};
   endfunction

   // True for operations that move data towards the device
   function automatic logic is_write(input fdh_pkg::op_t op);
      is_write = (op == fdh_pkg::OP_WRITE) || (op == fdh_pkg::OP_PAGE_WR);
   endfunction

   // True for page operations, which end with a signature read
   function automatic logic is_page(input fdh_pkg::op_t op);
      is_page = (op == fdh_pkg::OP_PAGE_RD) || (op == fdh_pkg::OP_PAGE_WR);
   endfunction

   state_t state_r, state_nxt;
   fdh_pkg::cmd_t cmd_r, cmd_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [9:0] idx_r, idx_nxt;
   logic [2:0] sidx_r, sidx_nxt;
   logic sig_ph_r, sig_ph_nxt;
   logic [47:0] sig_r, sig_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic done_r, done_nxt;
   logic pgv_r, pgv_nxt;
   logic [7:0] pgd_r, pgd_nxt;
   logic [12:0] addr_r, addr_nxt;
   logic [7:0] dout_r, dout_nxt;
   logic oe_r, oe_nxt;
   fdh_pkg::strobe_t strb_r, strb_nxt;
   logic ram_we;
   logic [7:0] ram_q;

   // ------------------------------------------------------------------
   // Page buffer
   // ------------------------------------------------------------------
   // Buffer lets a page go out with strobes at full rate, never stalling
   // mid-cycle on the feeding side.
   assign ram_we = (state_r == ST_FILL) && i_pg_wvalid;

   fdh_page_ram u_ram
   (
      .i_mclk(i_mclk),
      .i_we(ram_we),
      .i_waddr(idx_r[8:0]),
      .i_wdata(i_pg_wdata),
      .i_raddr(idx_nxt[8:0]), // Next index, so the byte is ready in NEXT
      .o_rdata(ram_q)
   );

   // Handshakes are combinational
   assign o_cmd_ready = (state_r == ST_IDLE);
   assign o_pg_wready = (state_r == ST_FILL);

   // ------------------------------------------------------------------
   // Sequencer next state
   // ------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      cnt_nxt = cnt_r;
      idx_nxt = idx_r;
      sidx_nxt = sidx_r;
      sig_ph_nxt = sig_ph_r;
      sig_nxt = sig_r;
      rdata_nxt = rdata_r;
      done_nxt = 1'b0;
      pgv_nxt = 1'b0;
      pgd_nxt = pgd_r;
      addr_nxt = addr_r;
      dout_nxt = dout_r;
      oe_nxt = oe_r;
      strb_nxt = strb_r;
      case (state_r)
         ST_IDLE:
         begin
            if (i_cmd_valid)
            begin
               cmd_nxt = i_cmd;
               idx_nxt = 10'h000;
               sidx_nxt = 3'h0;
               sig_ph_nxt = 1'b0;
               if (i_cmd.op == fdh_pkg::OP_PAGE_WR)
               begin
                  state_nxt = ST_FILL;
               end
               else
               begin
                  state_nxt = ST_SETUP;
                  cnt_nxt = fdh_pkg::SETUP_CNT;
                  // Single ops reach any section as given
                  addr_nxt = is_page(i_cmd.op) ?
                     flash_addr(i_cmd.addr) : i_cmd.addr;
                  dout_nxt = i_cmd.data;
               end
            end
         end
         ST_FILL:
         begin
            if (i_pg_wvalid)
            begin
               if (idx_r == fdh_pkg::PAGE_LAST)
               begin
                  idx_nxt = 10'h000;
                  state_nxt = ST_NEXT;
               end
               else
               begin
                  idx_nxt = idx_r + 10'h001;
               end
            end
         end
         ST_NEXT:
         begin
            // One cycle for the buffer's registered read to settle
            state_nxt = ST_SETUP;
            cnt_nxt = fdh_pkg::SETUP_CNT;
            addr_nxt = sig_ph_r ? cmd_r.addr : flash_addr(cmd_r.addr);
            dout_nxt = ram_q;
         end
         ST_SETUP:
         begin
            // Address and data settle before the strobe falls
            // Host drives the bus only for writes, so the device can own
            // it during reads without contention.
            oe_nxt = is_write(cmd_r.op) && !sig_ph_r;
            if (cnt_r <= 4'h1)
            begin
               state_nxt = ST_STROBE;
               cnt_nxt = fdh_pkg::STROBE_CNT;
               strb_nxt.n_ce = 1'b0;
               if (is_write(cmd_r.op) && !sig_ph_r)
               begin
                  strb_nxt.n_we = 1'b0;
               end
               else
               begin
                  strb_nxt.n_oe = 1'b0;
               end
            end
            else
            begin
               cnt_nxt = cnt_r - 4'h1;
            end
         end
         ST_STROBE:
         begin
            // Device has no clock: the strobe width alone paces it
            if (cnt_r <= 4'h1)
            begin
               state_nxt = ST_HOLD;
               cnt_nxt = fdh_pkg::HOLD_CNT;
               strb_nxt = '{n_ce: 1'b1, n_oe: 1'b1, n_we: 1'b1};
               if (sig_ph_r)
               begin
                  // Signature bytes arrive lowest first
                  sig_nxt[8*sidx_r +: 8] = i_data;
               end
               else if (!is_write(cmd_r.op))
               begin
                  rdata_nxt = i_data;
                  pgd_nxt = i_data;
                  pgv_nxt = (cmd_r.op == fdh_pkg::OP_PAGE_RD);
               end
            end
            else
            begin
               cnt_nxt = cnt_r - 4'h1;
            end
         end
         ST_HOLD:
         begin
            if (cnt_r <= 4'h1)
            begin
               oe_nxt = 1'b0;
               if (!is_page(cmd_r.op))
               begin
                  state_nxt = ST_IDLE;
                  done_nxt = 1'b1;
               end
               else if (sig_ph_r)
               begin
                  if (sidx_r == fdh_pkg::SIG_LAST)
                  begin
                     state_nxt = ST_IDLE;
                     done_nxt = 1'b1;
                  end
                  else
                  begin
                     sidx_nxt = sidx_r + 3'h1;
                     cmd_nxt.addr = cmd_r.addr + 13'h0001;
                     state_nxt = ST_NEXT;
                  end
               end
               else if (idx_r == fdh_pkg::PAGE_LAST)
               begin
                  // Page done: read signature bytes from the control section, at the offset in the command data
                  sig_ph_nxt = 1'b1;
                  cmd_nxt.addr = {fdh_pkg::SEC_CTRL, 3'h0, cmd_r.data};
                  state_nxt = ST_NEXT;
               end
               else
               begin
                  idx_nxt = idx_r + 10'h001;
                  state_nxt = ST_NEXT;
               end
            end
            else
            begin
               cnt_nxt = cnt_r - 4'h1;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Sequencer registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_r <= ST_IDLE;
         cmd_r <= '0;
         cnt_r <= 4'h0;
         idx_r <= 10'h000;
         sidx_r <= 3'h0;
         sig_ph_r <= 1'b0;
         sig_r <= 48'h000000000000;
         rdata_r <= 8'h00;
         done_r <= 1'b0;
         pgv_r <= 1'b0;
         pgd_r <= 8'h00;
         addr_r <= 13'h0000;
         dout_r <= 8'h00;
         oe_r <= 1'b0;
         strb_r <= '{n_ce: 1'b1, n_oe: 1'b1, n_we: 1'b1};
      end
      else
      begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         cnt_r <= cnt_nxt;
         idx_r <= idx_nxt;
         sidx_r <= sidx_nxt;
         sig_ph_r <= sig_ph_nxt;
         sig_r <= sig_nxt;
         rdata_r <= rdata_nxt;
         done_r <= done_nxt;
         pgv_r <= pgv_nxt;
         pgd_r <= pgd_nxt;
         addr_r <= addr_nxt;
         dout_r <= dout_nxt;
         oe_r <= oe_nxt;
         strb_r <= strb_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs, all from flip-flops
   // ------------------------------------------------------------------
   assign o_addr = addr_r;
   assign o_data = dout_r;
   assign o_data_oe = oe_r;
   assign o_strb_n = strb_r;
   assign o_done = done_r;
   assign o_rdata = rdata_r;
   assign o_sig = sig_r;
   assign o_pg_rvalid = pgv_r;
   assign o_pg_rdata = pgd_r;

endmodule

/* File: rtl/fdh_pkg.sv */
// Package for the flash disk host port controller
package fdh_pkg;

   // ------------------------------------------------------------------
   // Window geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int SEC_W = 2;
   localparam logic [1:0] SEC_BOOT0 = 2'h0;
   localparam logic [1:0] SEC_BOOT1 = 2'h1;
   localparam logic [1:0] SEC_CTRL = 2'h2;
   localparam logic [1:0] SEC_FLASH = 2'h3;
   localparam int SEC_POS = 11;
   localparam int BOOT_BYTES = 64;
   localparam int PAGE_BYTES = 512;
   localparam int SIG_BYTES = 6;
   localparam logic [9:0] PAGE_LAST = 10'h1FF;
   localparam logic [2:0] SIG_LAST = 3'h5;

   // ------------------------------------------------------------------
   // Cycle timing at 40 MHz
   // ------------------------------------------------------------------
   localparam int CLK_NS = 25;
   localparam int SETUP_NS = 25;
   localparam int STROBE_NS = 150;
   localparam int HOLD_NS = 25;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
   localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
   localparam logic [3:0] HOLD_CNT = 4'(HOLD_CYC);

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_PAGE_RD = 2'h2,
      OP_PAGE_WR = 2'h3
   } op_t;

   typedef struct packed
   {
      op_t op;
      logic [12:0] addr;
      logic [7:0] data;
   } cmd_t;

   typedef struct packed
   {
      logic n_ce;
      logic n_oe;
      logic n_we;
   } strobe_t;

endpackage

/* File: rtl/fdh_page_ram.sv */
// Page buffer memory with registered read data
module fdh_page_ram
(
   // Clock
   input wire logic i_mclk,
   // Write port
   input wire logic i_we,
   input wire logic [8:0] i_waddr,
   input wire logic [7:0] i_wdata,
   // Read port
   input wire logic [8:0] i_raddr,
   output logic [7:0] o_rdata
);

   logic [7:0] mem [0:511];

   // ------------------------------------------------------------------
   // Storage; no reset so it maps onto block memory
   // ------------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_we)
      begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end

endmodule

/* File: bench/fdh_host_properties.sv */
// Assertion checker for the flash disk host port controller
module fdh_host_properties
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Command side
   input wire logic i_cmd_valid,
   input wire fdh_pkg::cmd_t i_cmd,
   input wire logic o_cmd_ready,
   input wire logic o_done,
   // Device pins
   input wire logic [12:0] o_addr,
   input wire logic [7:0] o_data,
   input wire logic o_data_oe,
   input wire fdh_pkg::strobe_t o_strb_n
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   // Short names for the strobes and the command take
   logic ce_n, oe_n, we_n, take, single;
   assign ce_n = o_strb_n.n_ce;
   assign oe_n = o_strb_n.n_oe;
   assign we_n = o_strb_n.n_we;
   assign take = i_cmd_valid && o_cmd_ready;
   assign single = !i_cmd.op[1];

   a_strobe_width: assert property (
      $fell(ce_n) |-> !ce_n [*6] ##1 ce_n)
      else $error("select low time wrong");
   a_strobe_pair: assert property (
      (!oe_n || !we_n) |-> !ce_n && (oe_n || we_n))
      else $error("strobe without select or both strobes low");
   a_read_release: assert property (
      !oe_n |-> !o_data_oe)
      else $error("host drives data during read");
   a_write_drive: assert property (
      !we_n |-> o_data_oe && $stable(o_data) && $stable(o_addr))
      else $error("write data not held");
   a_addr_hold: assert property (
      !ce_n |-> $stable(o_addr))
      else $error("address moved while selected");
   a_done_time: assert property (
      take && single |=> !o_done [*8] ##1 o_done)
      else $error("done not nine cycles after take");
   a_busy_after: assert property (
      take |=> !o_cmd_ready)
      else $error("ready while busy");
   a_write_addr: assert property (
      take && i_cmd.op == fdh_pkg::OP_WRITE |-> ##2 (!we_n
      && o_addr == $past(i_cmd.addr, 2) && o_data == $past(i_cmd.data, 2)))
      else $error("write address or data wrong");
   a_read_sel: assert property (
      take && i_cmd.op == fdh_pkg::OP_READ |-> ##2 (!oe_n && we_n))
      else $error("read strobe missing");
   a_done_pulse: assert property (
      o_done |=> !o_done)
      else $error("done longer than one cycle");
endmodule

/* File: bench/fdh_dev_model.sv */
// Behavioural flash disk device answering its strobe pins
module fdh_dev_model
(
   // Device pins
   input wire logic [12:0] i_addr,
   input wire fdh_pkg::strobe_t i_strb_n,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe
);
   logic [7:0] mem [0:8191];
   logic [7:0] last = 8'h5A;
   logic wr_n;
   logic [12:0] loc;

   // Boot sections hold 64 bytes each, seen again across the section
   assign loc = i_addr[12] ? i_addr : {i_addr[12:11], 5'h00, i_addr[5:0]};
   // above: four sections, boot bytes aliased

   // No clock: select and strobes alone frame each access
   assign wr_n = i_strb_n.n_ce | i_strb_n.n_we;
   always @(posedge wr_n)
      mem[loc] = i_data;

   // Drive only in a read; a released bus shows a changed value
   assign o_data_oe = !(i_strb_n.n_ce | i_strb_n.n_oe);
   assign o_data = o_data_oe ? mem[loc] : ~last;
   always @(negedge o_data_oe)
      last = mem[loc];
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the flash disk host port controller
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic sys_rst, cmd_valid, cmd_ready, pg_wvalid, pg_wready;
   logic pg_rvalid, done, data_oe, dm_oe;
   logic [7:0] pg_wdata, pg_rdata, rdata, hdata, dm_d, bus;
   logic [12:0] addr;
   logic [47:0] sig;
   fdh_pkg::cmd_t cmd;
   fdh_pkg::strobe_t strb_n;
   int error_cnt = 0;
   int n_tests = 0;
   int k, n, pulses;

   always #12.5 mclk = ~mclk;
   // Host drives the bus only when the device does not
   assign bus = (data_oe && !dm_oe) ? hdata : dm_d;

   fdh_host DUT (.i_mclk(mclk), .i_sys_rst(sys_rst),
      .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(cmd_ready),
      .i_pg_wvalid(pg_wvalid), .i_pg_wdata(pg_wdata),
      .o_pg_wready(pg_wready), .o_pg_rvalid(pg_rvalid),
      .o_pg_rdata(pg_rdata), .o_done(done), .o_rdata(rdata), .o_sig(sig),
      .o_addr(addr), .i_data(bus), .o_data(hdata), .o_data_oe(data_oe),
      .o_strb_n(strb_n));
   fdh_dev_model dev (.i_addr(addr), .i_strb_n(strb_n), .i_data(bus),
      .o_data(dm_d), .o_data_oe(dm_oe));

   // Edges from take to a visible done: setup, strobe and hold
   localparam int CMD_CYC = fdh_pkg::SETUP_CYC + fdh_pkg::STROBE_CYC
      + fdh_pkg::HOLD_CYC;

   task check(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task complete_run;
      if (error_cnt == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One command; page bytes fed when asked; bounded wait for done
   task run_cmd(input fdh_pkg::op_t op, input logic [12:0] a,
      input logic [7:0] d, input logic [7:0] pexp);
      @(posedge mclk);
      k = 0;
      n = 0;
      pulses = 0;
      cmd_valid <= 1'b1;
      cmd <= '{op, a, d};
      @(posedge mclk);
      cmd_valid <= 1'b0;
      while (op == fdh_pkg::OP_PAGE_WR && k < 512)
      begin
         pg_wvalid <= 1'b1;
         pg_wdata <= 8'(k * 3);
         @(posedge mclk);
         if (pg_wready === 1'b1)
            k++;
      end
      pg_wvalid <= 1'b0;
      do
      begin
         @(posedge mclk);
         #1;
         n++;
         if (pg_rvalid === 1'b1)
         begin
            pulses++;
            check(pg_rdata, pexp);
         end
      end while (done !== 1'b1 && n < 6000);
      check(done, 1'b1);
   endtask

   // Single writes then reads back, top address included
   task t_single;
      for (int j = 0; j < 7; j++)
      begin
         run_cmd(fdh_pkg::OP_WRITE, 13'h1000 + 13'(j), 8'h30 + 8'(j), 0);
         check(n, CMD_CYC);
      end
      run_cmd(fdh_pkg::OP_WRITE, 13'h1FFF, 8'hC3, 0);
      run_cmd(fdh_pkg::OP_READ, 13'h1FFF, 8'h00, 0);
      check(n, CMD_CYC);
      check(rdata, 8'hC3);
      run_cmd(fdh_pkg::OP_READ, 13'h1003, 8'h00, 0);
      check(rdata, 8'h33);
      run_cmd(fdh_pkg::OP_WRITE, 13'h0805, 8'h5C, 0);
      run_cmd(fdh_pkg::OP_READ, 13'h0FC5, 8'h00, 0);
      check(rdata, 8'h5C);
   endtask

   // Page write: all bytes to one window place, then signature
   task t_page_wr;
      run_cmd(fdh_pkg::OP_PAGE_WR, 13'h0005, 8'h00, 0);
      check(pulses, 0);
      check(sig, 48'h353433323130);
      run_cmd(fdh_pkg::OP_READ, 13'h1805, 8'h00, 0);
      check(rdata, 8'hFD);
   endtask

   // Page read of the same place, signature from another base
   task t_page_rd;
      run_cmd(fdh_pkg::OP_PAGE_RD, 13'h0005, 8'h01, 8'hFD);
      check(pulses, 512);
      check(sig, 48'h363534333231);
   endtask

   // Reset in mid-write must park the pins, then work resumes
   task t_reset;
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd <= '{fdh_pkg::OP_WRITE, 13'h1000, 8'hEE};
      @(posedge mclk);
      cmd_valid <= 1'b0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b1;
      @(posedge mclk);
      #1;
      check({strb_n, data_oe, cmd_ready}, 5'h1D);
      @(posedge mclk);
      sys_rst <= 1'b0;
      run_cmd(fdh_pkg::OP_READ, 13'h1001, 8'h00, 0);
      check(rdata, 8'h31);
   endtask

   initial
   begin
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      pg_wvalid = 1'b0;
      pg_wdata = 8'h00;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_single;
      t_page_wr;
      t_page_rd;
      t_reset;
      complete_run;
   end

   // Watchdog well beyond the two page transfers
   initial
   begin
      #1000000;
      error_cnt++;
      complete_run;
   end
endmodule

bind fdh_host fdh_host_properties chk (.i_mclk, .i_sys_rst, .i_cmd_valid,
   .i_cmd, .o_cmd_ready, .o_done, .o_addr, .o_data, .o_data_oe, .o_strb_n);
